// *** hdl/csacal_top.sv ***
// current sense amplifier gain, reference, calibration and drain sense control with AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module csacal_top
    import csacal_pkg::*;
#(
    parameter int ADDR_W         = AXI_ADDR_W,
    parameter int AUTOCAL_LEN    = AUTOCAL_CYCLES,
    parameter bit HW_VARIANT     = 1'b0
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 calPin,
    input  wire logic                 vrefReady,
    input  wire logic [NUM_AMPS-1:0]  lowsideOn,
    input  wire logic [NUM_AMPS-1:0]  gateDriveWindow,
    output logic [1:0]                ampGain,
    output logic                      unidirMode,
    output logic                      lowsideMonitorRefSelect,
    output logic [NUM_AMPS-1:0]       ampInShort,
    output logic [NUM_AMPS-1:0]       shuntDisconnect,
    output logic [NUM_AMPS-1:0]       lowsideDrainConnect,
    output logic [NUM_AMPS-1:0]       ampEnable,
    output logic [NUM_AMPS-1:0]       ampOutValid,
    output logic                      trimStore,
    output logic                      autoCalBusy
);
    csacal_gain_e           ampGainCfg_q;
    logic                   unidirCfg_q;
    logic                   calMode_q;
    logic                   fetDropSenseEnable_q;
    logic                   lowsideRefCfg_q;
    logic [NUM_AMPS-1:0]    ampCalRequest_q;
    logic [1:0]             calPinSync_q;
    logic [1:0]             vrefSync_q;
    logic                   calPinLvl;
    logic                   vrefOk;
    logic                   powerupPending_q;
    logic                   powerupDone_q;
    logic                   trigLvl;
    logic                   trigLvl_q;
    logic                   autoMode;
    logic [NUM_AMPS-1:0]    manualCal;
    logic                   awHeld_q;
    logic                   wHeld_q;
    logic [ADDR_W-1:0]      awAddr_q;
    logic [31:0]            wData_q;
    logic [3:0]             wStrb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rdata_q;
    logic                   doWrite;
    logic                   wrHit;
    logic [31:0]            readWord;
    logic                   rdHit;
    logic [31:0]            statusWord;

    csacal_auto_if ac ();

    // pins from outside the clock domain: the first stage is read only by the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            calPinSync_q <= 2'h0;
            vrefSync_q   <= 2'h0;
        end else begin
            calPinSync_q <= {calPinSync_q[0], calPin};
            vrefSync_q   <= {vrefSync_q[0], vrefReady};
        end
    end

    assign calPinLvl = calPinSync_q[1];
    assign vrefOk    = vrefSync_q[1];

    // the hardware variant ignores the request bits; after power-up it calibrates only manually, from the pin
    assign autoMode = calMode_q && !HW_VARIANT;
    assign trigLvl  = calPinLvl || (|ampCalRequest_q && !HW_VARIANT);
    assign manualCal = autoMode ? '0 :
                       ({NUM_AMPS{calPinLvl}} | (HW_VARIANT ? '0 : ampCalRequest_q));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trigLvl_q <= 1'b0;
        end else begin
            trigLvl_q <= trigLvl;
        end
    end

    // power-up routine waits for the reference; a run-time request that lands mid-routine is dropped
    assign ac.start = !ac.busy && ((powerupPending_q && vrefOk) ||
                                   (autoMode && trigLvl && !trigLvl_q));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            powerupPending_q <= 1'b1;
            powerupDone_q    <= 1'b0;
        end else begin
            if (ac.start && powerupPending_q && vrefOk) begin
                powerupPending_q <= 1'b0;
            end
            if (ac.done && !powerupPending_q) begin
                powerupDone_q <= 1'b1;
            end
        end
    end

    csacal_autocal #(
        .CYCLES (AUTOCAL_LEN)
    ) u_autocal (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ac    (ac)
    );

    assign autoCalBusy = ac.busy;

    // global analog steering: gain and unidirectional mode follow busy one cycle late; the reference select ignores the routine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ampGain                 <= GAIN_RESET;
            unidirMode              <= UNIDIR_RESET;
            lowsideMonitorRefSelect <= LSREF_RESET;
            trimStore               <= 1'b0;
        end else begin
            ampGain                 <= ac.busy ? GAIN_MAX : ampGainCfg_q;
            unidirMode              <= unidirCfg_q && !ac.busy;
            lowsideMonitorRefSelect <= fetDropSenseEnable_q || lowsideRefCfg_q;
            trimStore               <= ac.done;
        end
    end

    for (genvar i = 0; i < NUM_AMPS; i++) begin : g_amp
        csacal_amp_path u_amp (
            .mclk                (mclk),
            .rst_n               (rst_n),
            .manualCal           (manualCal[i]),
            .autoBusy            (ac.busy),
            .fetDropSenseEnable  (fetDropSenseEnable_q),
            .lowsideOn           (lowsideOn[i]),
            .gateDriveWindow     (gateDriveWindow[i]),
            .ampInShort          (ampInShort[i]),
            .shuntDisconnect     (shuntDisconnect[i]),
            .lowsideDrainConnect (lowsideDrainConnect[i]),
            .ampEnable           (ampEnable[i]),
            .ampOutValid         (ampOutValid[i])
        );
    end

    // write channel: address and data taken in either order, answered once both are held
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign doWrite       = awHeld_q && wHeld_q && !bvalid_q;
    assign wrHit         = (awAddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) ||
                           (awAddr_q[ADDR_W-1:2] == OFF_CALREQ[ADDR_W-1:2]) ||
                           (awAddr_q[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= '0;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // configuration lives in byte lane 0; status is read-only and ignores writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ampGainCfg_q         <= GAIN_RESET;
            unidirCfg_q          <= UNIDIR_RESET;
            calMode_q            <= CALMODE_RESET;
            fetDropSenseEnable_q <= FET_RESET;
            lowsideRefCfg_q      <= LSREF_RESET;
        end else if (doWrite && wStrb_q[0] && (awAddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2])) begin
            ampGainCfg_q         <= csacal_gain_e'(wData_q[CTRL_GAIN_LSB +: 2]);
            unidirCfg_q          <= wData_q[CTRL_UNIDIR_BIT];
            calMode_q            <= wData_q[CTRL_CALMODE_BIT];
            fetDropSenseEnable_q <= wData_q[CTRL_FET_BIT];
            lowsideRefCfg_q      <= wData_q[CTRL_LSREF_BIT];
        end
    end

    // requests are taken at any moment, busy or not; gate drive never waits on them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ampCalRequest_q <= CALREQ_RESET;
        end else if (doWrite && wStrb_q[0] && (awAddr_q[ADDR_W-1:2] == OFF_CALREQ[ADDR_W-1:2])) begin
            ampCalRequest_q <= wData_q[NUM_AMPS-1:0];
        end
    end

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_comb begin
        statusWord                                   = 32'h0;
        statusWord[STAT_BUSY_BIT]                    = ac.busy;
        statusWord[STAT_PUDONE_BIT]                  = powerupDone_q;
        statusWord[STAT_INCAL_LSB +: NUM_AMPS]       = manualCal | {NUM_AMPS{ac.busy}};
        statusWord[STAT_PIN_BIT]                     = calPinLvl;
        statusWord[STAT_GAIN_LSB +: 2]               = ampGain;
        statusWord[STAT_HW_BIT]                      = HW_VARIANT;
    end

    always_comb begin
        readWord = 32'h0;
        rdHit    = 1'b1;
        if (s_axi_araddr[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) begin
            readWord[CTRL_GAIN_LSB +: 2]  = ampGainCfg_q;
            readWord[CTRL_UNIDIR_BIT]     = unidirCfg_q;
            readWord[CTRL_CALMODE_BIT]    = calMode_q;
            readWord[CTRL_FET_BIT]        = fetDropSenseEnable_q;
            readWord[CTRL_LSREF_BIT]      = lowsideRefCfg_q;
        end else if (s_axi_araddr[ADDR_W-1:2] == OFF_CALREQ[ADDR_W-1:2]) begin
            readWord[NUM_AMPS-1:0] = ampCalRequest_q;
        end else if (s_axi_araddr[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]) begin
            readWord = statusWord;
        end else begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= readWord;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    a_gain_forced: assert property (@(posedge mclk) disable iff (!rst_n)
        ac.busy |=> ampGain == GAIN_MAX) else $error("gain not forced to maximum");
    a_gain_restore: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ac.busy && $past(!ac.busy)) |-> ampGain == $past(ampGainCfg_q)) else $error("programmed gain not applied");
    a_unidir_suspend: assert property (@(posedge mclk) disable iff (!rst_n)
        ac.busy |=> !unidirMode) else $error("unidirectional kept during routine");
    a_unidir_restore: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ac.busy && unidirCfg_q) |=> unidirMode) else $error("unidirectional mode not restored");
    a_single_amp: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ac.busy && !autoMode && !calPinLvl && !HW_VARIANT && ampCalRequest_q == 3'h1 && !fetDropSenseEnable_q)
        |=> shuntDisconnect == 3'h1) else $error("request did not isolate one amplifier");
    a_pin_all: assert property (@(posedge mclk) disable iff (!rst_n)
        (calPinLvl && !autoMode) |=> (ampInShort == 3'h7 && shuntDisconnect == 3'h7)) else $error("pin did not short all");
    a_powerup_start: assert property (@(posedge mclk) disable iff (!rst_n)
        (powerupPending_q && vrefOk && !ac.busy) |=> ac.busy ##1 !powerupPending_q) else $error("power-up calibration late");
    a_cal_type: assert property (@(posedge mclk) disable iff (!rst_n)
        (autoMode && trigLvl && !trigLvl_q && !ac.busy) |=> (ac.busy && manualCal == '0)) else $error("auto mode not run");
    a_trim_store: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(ac.busy) |-> trimStore ##1 !trimStore) else $error("trim not stored at end");
    a_req_taken: assert property (@(posedge mclk) disable iff (!rst_n)
        (doWrite && awAddr_q[ADDR_W-1:2] == OFF_CALREQ[ADDR_W-1:2]) |=> (bvalid_q && bresp_q == RESP_OKAY))
        else $error("calibration request refused");
    a_fet_ref: assert property (@(posedge mclk) disable iff (!rst_n)
        fetDropSenseEnable_q |=> lowsideMonitorRefSelect) else $error("monitor reference not forced");
    a_fet_window: assert property (@(posedge mclk) disable iff (!rst_n)
        (fetDropSenseEnable_q && gateDriveWindow[0]) |=> (!ampOutValid[0] && !lowsideDrainConnect[0]))
        else $error("output valid inside drive window");
    a_fet_off_short: assert property (@(posedge mclk) disable iff (!rst_n)
        (fetDropSenseEnable_q && !lowsideOn[1]) |=> ampInShort[1]) else $error("inputs not shorted while off");
endmodule

// *** pkg/csacal_pkg.sv ***
// constants, types and register map of the current sense amplifier calibration control
package csacal_pkg;
    localparam int          NUM_AMPS        = 3;
    localparam int          AXI_ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_CALREQ      = 8'h04;
    localparam logic [7:0]  OFF_STATUS      = 8'h08;
    localparam int          CTRL_GAIN_LSB   = 0;
    localparam int          CTRL_UNIDIR_BIT = 2;
    localparam int          CTRL_CALMODE_BIT = 3;
    localparam int          CTRL_FET_BIT    = 4;
    localparam int          CTRL_LSREF_BIT  = 5;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_PUDONE_BIT = 1;
    localparam int          STAT_INCAL_LSB  = 2;
    localparam int          STAT_PIN_BIT    = 5;
    localparam int          STAT_GAIN_LSB   = 6;
    localparam int          STAT_HW_BIT     = 8;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [2:0]  CALREQ_RESET    = 3'h0;
    localparam logic        UNIDIR_RESET    = 1'b0;
    localparam logic        CALMODE_RESET   = 1'b0;
    localparam logic        FET_RESET       = 1'b0;
    localparam logic        LSREF_RESET     = 1'b0;
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          AUTOCAL_TIME_US = 50;
    // longest time: rounds down to whole cycles
    localparam int          AUTOCAL_CYCLES  = (AUTOCAL_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int          AUTOCAL_CNT_W   = 16;

    typedef enum logic [1:0] {
        CSACAL_GAIN_5  = 2'h0,
        CSACAL_GAIN_10 = 2'h1,
        CSACAL_GAIN_20 = 2'h2,
        CSACAL_GAIN_40 = 2'h3
    } csacal_gain_e;

    localparam csacal_gain_e GAIN_RESET = CSACAL_GAIN_5;
    localparam csacal_gain_e GAIN_MAX   = CSACAL_GAIN_40;

    typedef enum logic [1:0] {
        CSACAL_AC_IDLE = 2'b01,
        CSACAL_AC_RUN  = 2'b10
    } csacal_acst_e;
endpackage

// *** pkg/csacal_auto_if.sv ***
// handshake between the control logic and the auto calibration timer
`timescale 1ns/1ps
interface csacal_auto_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

// *** hdl/csacal_autocal.sv ***
// auto calibration routine timer
`timescale 1ns/1ps
module csacal_autocal
    import csacal_pkg::*;
#(
    parameter int CYCLES = AUTOCAL_CYCLES
) (
    input  wire logic   mclk,
    input  wire logic   rst_n,
    csacal_auto_if.timer ac
);
    csacal_acst_e              state_q;
    logic [AUTOCAL_CNT_W-1:0]  cnt_q;
    logic [AUTOCAL_CNT_W-1:0]  busyCnt_q;

    // start while running is ignored: the routine is never stretched
    assign ac.busy = (state_q == CSACAL_AC_RUN);
    assign ac.done = ac.busy && (cnt_q == AUTOCAL_CNT_W'(CYCLES - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CSACAL_AC_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                CSACAL_AC_IDLE: begin
                    cnt_q <= '0;
                    if (ac.start) begin
                        state_q <= CSACAL_AC_RUN;
                    end
                end
                CSACAL_AC_RUN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (ac.done) begin
                        state_q <= CSACAL_AC_IDLE;
                    end
                end
                default: state_q <= CSACAL_AC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_q <= '0;
        end else begin
            busyCnt_q <= ac.busy ? busyCnt_q + 1'b1 : '0;
        end
    end

    a_routine_length: assert property (@(posedge mclk) disable iff (!rst_n)
        busyCnt_q <= AUTOCAL_CNT_W'(CYCLES)) else $error("auto calibration exceeds its time");
    a_routine_full: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(ac.busy) |-> $past(busyCnt_q) == AUTOCAL_CNT_W'(CYCLES - 1)) else $error("auto calibration ended early");
endmodule

// *** hdl/csacal_amp_path.sv ***
// input switching and output qualification of one sense amplifier
`timescale 1ns/1ps
module csacal_amp_path (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic manualCal,
    input  wire logic autoBusy,
    input  wire logic fetDropSenseEnable,
    input  wire logic lowsideOn,
    input  wire logic gateDriveWindow,
    output logic      ampInShort,
    output logic      shuntDisconnect,
    output logic      lowsideDrainConnect,
    output logic      ampEnable,
    output logic      ampOutValid
);
    logic calActive;
    logic enD;

    assign calActive = manualCal || autoBusy;
    // drain sense: amplifier only wakes after the drive window, when the drain settles
    assign enD = fetDropSenseEnable ? (lowsideOn && !gateDriveWindow) : 1'b1;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ampInShort          <= 1'b0;
            shuntDisconnect     <= 1'b0;
            lowsideDrainConnect <= 1'b0;
            ampEnable           <= 1'b0;
            ampOutValid         <= 1'b0;
        end else begin
            ampInShort          <= calActive || (fetDropSenseEnable && !lowsideOn);
            shuntDisconnect     <= calActive || fetDropSenseEnable;
            lowsideDrainConnect <= fetDropSenseEnable && enD && !calActive;
            ampEnable           <= enD;
            ampOutValid         <= enD && !calActive;
        end
    end
endmodule

// *** test/csacal_host_model.sv ***
// host controller model: reference supply and calibration pin
`timescale 1ns/1ps
module csacal_host_model (
    input  wire logic mclk,
    input  wire logic calReq,
    output logic      calPin,
    output logic      vrefReady
);
    initial begin
        vrefReady = 1'b0;
        #60 vrefReady = 1'b1;
    end
    // pin is a plain level; the host holds it as long as the bench asks
    always @(posedge mclk) calPin <= calReq;
endmodule

// *** test/tb_top.sv ***
// self-checking bench of the sense amplifier calibration control
`timescale 1ns/1ps
module tb_top import csacal_pkg::*; ();
    localparam int LEN = 20;
    logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, calPin, vrefReady, calReq;
    logic        unidirMode, lowsideMonitorRefSelect, trimStore, autoCalBusy;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ampGain;
    logic [2:0]  lowsideOn, gateDriveWindow, ampInShort, shuntDisconnect, lowsideDrainConnect, ampEnable, ampOutValid;
    logic [33:0] expQ[$];
    int          n_fail, checked;
    csacal_top #(.AUTOCAL_LEN(LEN)) i_dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .calPin, .vrefReady, .lowsideOn, .gateDriveWindow, .ampGain, .unidirMode, .lowsideMonitorRefSelect,
        .ampInShort, .shuntDisconnect, .lowsideDrainConnect, .ampEnable, .ampOutValid, .trimStore, .autoCalBusy);
    csacal_host_model i_host (.mclk, .calReq, .calPin, .vrefReady);
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ready is looked at on the taking edge itself; each channel lets go right after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge mclk);
            {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & ~s_axi_awready, s_axi_wvalid & ~s_axi_wready};
        end while (s_axi_bvalid !== 1'b1);
        chk(34'(s_axi_bresp), (a[7:2] < 6'h3) ? 34'(RESP_OKAY) : 34'(RESP_SLVERR));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expQ.push_back(e);
        @(posedge mclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge mclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // routine length is counted in cycles; the forced outputs trail busy by one cycle
    task automatic autocal(input logic [1:0] g, input logic u);
        int n;
        n = 0;
        while (autoCalBusy !== 1'b1) @(negedge mclk);
        while (autoCalBusy === 1'b1) begin
            @(negedge mclk);
            n++;
            if (n == 1) begin
                chk(34'(ampGain), 34'h3);
                chk(34'(unidirMode), 34'h0);
                chk(34'(shuntDisconnect), 34'h7);
                chk(34'(ampOutValid), 34'h0);
            end
        end
        chk(34'(n), 34'(LEN));
        chk(34'(trimStore), 34'h1);
        @(negedge mclk);
        chk(34'({trimStore, ampGain, unidirMode, ampInShort}), 34'({1'b0, g, u, 3'h0}));
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        logic [31:0] c;
        logic [2:0]  lo, win;
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, calReq} = '0;
        {lowsideOn, gateDriveWindow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 58'hf;
        void'($urandom(32'hdc8e));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        autocal(2'h0, 1'b0);
        rd(OFF_STATUS, 34'h2);
        $display("powerup done");
        for (int g = 0; g < 4; g++) begin
            c = {26'h0, 1'($urandom), 2'h0, 1'($urandom), 2'(g)};
            wr(OFF_CTRL, c);
            idle(2);
            chk(34'({ampGain, unidirMode}), 34'({2'(g), c[2]}));
            chk(34'(lowsideMonitorRefSelect), 34'(c[5]));
            rd(OFF_CTRL, {2'h0, c});
        end
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CALREQ, 32'(1 << i));
            lowsideOn <= 3'($urandom);
            idle(2);
            chk(34'({ampInShort, shuntDisconnect}), 34'({2{3'(1 << i)}}));
        end
        wr(OFF_CALREQ, 32'h0);
        calReq <= 1'b1;
        // host waits out the routine length before it trusts the shorted inputs
        idle(LEN);
        chk(34'({ampInShort, shuntDisconnect}), 34'h3f);
        @(posedge mclk) calReq <= 1'b0;
        wr(OFF_CTRL, 32'h0d);
        calReq <= 1'b1;
        autocal(2'h1, 1'b1);
        @(posedge mclk) calReq <= 1'b0;
        $display("calibration done");
        wr(OFF_CTRL, 32'h10);
        repeat (6) begin
            {lo, win} = 6'($urandom);
            @(posedge mclk);
            {lowsideOn, gateDriveWindow} <= {lo, win};
            idle(2);
            chk(34'(lowsideMonitorRefSelect), 34'h1);
            chk(34'({ampEnable, lowsideDrainConnect}), 34'({2{lo & ~win}}));
            chk(34'(ampInShort), 34'(3'(~lo)));
            chk(34'(ampOutValid), 34'(3'(lo & ~win)));
        end
        wr(8'h0c, 32'h3f);
        rd(OFF_CTRL, 34'h10);
        rd(8'h0c, {RESP_SLVERR, 32'h0});
        idle(4);
        $display("drain sense and bus done");
        tally_and_finish;
    end
endmodule
